// ---- src/asr_host.sv ----
// Host controller driving an asynchronous 8M x 8 static memory over its pins
// Notes on behaviour
// - Write stores byte when low select low, high select high, strobe low.
// - Read needs both selects active, gate low and strobe high.
// - Wait at least 100 us after power-up before first access.
// - Address stable at least 9 ns before write end.
// - Address may change with zero setup at write start, zero hold after.
// - Write data present 7 ns before write end, zero hold after.
// - Data setup and hold measured from the edge that ends the write.
// - Strobe-controlled write cycle no shorter than float delay plus setup.
`timescale 1ns/10ps
module asr_host (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic [asr_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [asr_pkg::DATA_W-1:0] req_wdata_i,
  output logic rsp_valid_o,
  output logic [asr_pkg::DATA_W-1:0] rsp_rdata_o,
  output logic init_done_o,
  output logic [asr_pkg::ADDR_W-1:0] location_inputs_o,
  output logic select_low_active_o,
  output logic select_high_active_o,
  output logic write_strobe_n_o,
  output logic output_gate_n_o,
  input wire logic [asr_pkg::DATA_W-1:0] byte_lines_i,
  output logic [asr_pkg::DATA_W-1:0] byte_lines_o,
  output logic byte_lines_oe_n_o
);
  asr_pkg::asr_state_e state_ff, nxt_state;
  logic [asr_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [asr_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
  logic [asr_pkg::DATA_W-1:0] wdata_ff, nxt_wdata;
  logic [asr_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
  logic sel_ff, nxt_sel;
  logic we_n_ff, nxt_we_n;
  logic oe_n_ff, nxt_oe_n;
  logic drive_n_ff, nxt_drive_n;
  logic rsp_ff, nxt_rsp;
  logic init_ff, nxt_init;
  logic [asr_pkg::DATA_W-1:0] rd_sync;

  // Byte lines come from another timing domain, so they are synchronised
  asr_sync #(
    .W(asr_pkg::DATA_W)
  ) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .d_i(byte_lines_i),
    .q_o(rd_sync)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    nxt_sel = sel_ff;
    nxt_we_n = we_n_ff;
    nxt_oe_n = oe_n_ff;
    nxt_drive_n = drive_n_ff;
    nxt_rsp = 1'b0;
    nxt_init = init_ff;
    if (ce_i) begin
      case (state_ff)
        asr_pkg::ASR_BOOT: begin
          // Deselected throughout start-up keeps the memory in standby
          if (cnt_ff == asr_pkg::CNT_ONE) begin
            nxt_state = asr_pkg::ASR_IDLE;
            nxt_init = 1'b1;
          end
          nxt_cnt = cnt_ff - asr_pkg::CNT_ONE;
        end
        asr_pkg::ASR_IDLE: begin
          if (req_valid_i) begin
            // Address, select and strobe change together: zero setup is allowed
            nxt_addr = req_addr_i;
            nxt_wdata = req_wdata_i;
            nxt_sel = 1'b1;
            if (req_write_i) begin
              nxt_state = asr_pkg::ASR_WRITE;
              nxt_we_n = 1'b0;
              nxt_oe_n = 1'b1;
              nxt_drive_n = 1'b0;
              nxt_cnt = asr_pkg::WR_LOW_CNT;
            end else begin
              nxt_state = asr_pkg::ASR_READ;
              nxt_we_n = 1'b1;
              nxt_oe_n = 1'b0;
              nxt_drive_n = 1'b1;
              nxt_cnt = asr_pkg::READ_CNT;
            end
          end
        end
        asr_pkg::ASR_READ: begin
          if (cnt_ff == asr_pkg::CNT_ZERO) begin
            // Sample before the address moves, inside the output keep window
            nxt_rdata = rd_sync;
            nxt_rsp = 1'b1;
            nxt_sel = 1'b0;
            nxt_oe_n = 1'b1;
            nxt_state = asr_pkg::ASR_DONE;
          end else begin
            nxt_cnt = cnt_ff - asr_pkg::CNT_ONE;
          end
        end
        asr_pkg::ASR_WRITE: begin
          if (cnt_ff == asr_pkg::CNT_ONE) begin
            // Strobe alone ends the write; data and address hold one more cycle
            nxt_we_n = 1'b1;
            nxt_state = asr_pkg::ASR_DONE;
          end
          nxt_cnt = cnt_ff - asr_pkg::CNT_ONE;
        end
        asr_pkg::ASR_DONE: begin
          // Recovery cycle covers the 12 ns cycle minimum and zero-hold release
          nxt_sel = 1'b0;
          nxt_drive_n = 1'b1;
          nxt_oe_n = 1'b1;
          nxt_state = asr_pkg::ASR_IDLE;
          if (!drive_n_ff) begin
            nxt_rsp = 1'b1;
          end
        end
        default: begin
          nxt_state = asr_pkg::ASR_IDLE;
          nxt_sel = 1'b0;
          nxt_we_n = 1'b1;
          nxt_oe_n = 1'b1;
          nxt_drive_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_ff <= asr_pkg::ASR_BOOT;
      cnt_ff <= asr_pkg::CNT_W'(asr_pkg::STARTUP_CYC);
      addr_ff <= '0;
      wdata_ff <= '0;
      rdata_ff <= '0;
      sel_ff <= 1'b0;
      we_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      drive_n_ff <= 1'b1;
      rsp_ff <= 1'b0;
      init_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      sel_ff <= nxt_sel;
      we_n_ff <= nxt_we_n;
      oe_n_ff <= nxt_oe_n;
      drive_n_ff <= nxt_drive_n;
      rsp_ff <= nxt_rsp;
      init_ff <= nxt_init;
    end
  end

  assign req_ready_o = ce_i && (state_ff == asr_pkg::ASR_IDLE);
  assign rsp_valid_o = rsp_ff;
  assign rsp_rdata_o = rdata_ff;
  assign init_done_o = init_ff;
  assign location_inputs_o = addr_ff;
  assign select_low_active_o = ~sel_ff;
  assign select_high_active_o = sel_ff;
  assign write_strobe_n_o = we_n_ff;
  assign output_gate_n_o = oe_n_ff;
  assign byte_lines_o = wdata_ff;
  assign byte_lines_oe_n_o = drive_n_ff;
endmodule

// ---- src/asr_pkg.sv ----
// Package with pin timing and geometry constants for the static memory host controller
package asr_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ADDR_W = 23;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DEPTH = 8388608;
  // Times in their own units, as printed
  localparam int unsigned STARTUP_WAIT_US = 100;
  localparam int unsigned ADDRESS_ACCESS_TIME_NS = 12;
  localparam int unsigned OUTPUT_KEEP_AFTER_ADDR_NS = 3;
  localparam int unsigned ADDR_TO_WRITE_END_NS = 9;
  localparam int unsigned ADDRESS_SETUP_BEGIN_NS = 0;
  localparam int unsigned ADDRESS_KEEP_AFTER_WRITE_NS = 0;
  localparam int unsigned DATA_SETUP_TIME_NS = 7;
  localparam int unsigned DATA_KEEP_TIME_NS = 0;
  localparam int unsigned WRITE_FLOAT_TIME_NS = 7;
  localparam int unsigned READ_CYCLE_NS = 12;
  localparam int unsigned WRITE_CYCLE_NS = 12;
  // Least times round up; one cycle at minimum
  function automatic int unsigned ceil_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int unsigned STARTUP_CYC = ceil_cyc(STARTUP_WAIT_US * 1000);
  // Read sample waits for access time plus two cycles for the input synchroniser: this +1 and the count down to zero
  localparam int unsigned READ_CYC = ceil_cyc(ADDRESS_ACCESS_TIME_NS) + 1;
  // Strobe low long enough for address-to-end and float-then-setup
  localparam int unsigned WR_LOW_CYC = ceil_cyc(
      (ADDR_TO_WRITE_END_NS > (WRITE_FLOAT_TIME_NS + DATA_SETUP_TIME_NS)) ?
      ADDR_TO_WRITE_END_NS : (WRITE_FLOAT_TIME_NS + DATA_SETUP_TIME_NS));
  localparam int unsigned CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
  localparam logic [CNT_W-1:0] READ_CNT = CNT_W'(READ_CYC);
  localparam logic [CNT_W-1:0] WR_LOW_CNT = CNT_W'(WR_LOW_CYC);
  typedef enum logic [2:0] {
    ASR_BOOT  = 3'b000,
    ASR_IDLE  = 3'b001,
    ASR_READ  = 3'b010,
    ASR_WRITE = 3'b011,
    ASR_DONE  = 3'b100
  } asr_state_e;
endpackage

// ---- src/asr_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module asr_sync #(
  parameter int unsigned W = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;
  always_comb begin
    nxt_meta = meta_ff;
    nxt_sync = sync_ff;
    if (ce_i) begin
      nxt_meta = d_i;
      nxt_sync = meta_ff;
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end
  assign q_o = sync_ff;
endmodule

// ---- verif/asr_host_chk.sv ----
// Checker of pin sequencing for the static memory host controller
`timescale 1ns/10ps
module asr_host_chk (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic req_ready_o,
  input wire logic init_done_o,
  input wire logic [asr_pkg::ADDR_W-1:0] location_inputs_o,
  input wire logic select_low_active_o,
  input wire logic select_high_active_o,
  input wire logic write_strobe_n_o,
  input wire logic output_gate_n_o,
  input wire logic [asr_pkg::DATA_W-1:0] byte_lines_o,
  input wire logic byte_lines_oe_n_o
);
  logic [13:0] cnt_ff;
  logic [13:0] nxt_cnt;
  wire sel = !select_low_active_o && select_high_active_o;
  always_comb nxt_cnt = sys_rst_i ? 14'h0000 : cnt_ff + {13'h0000, ce_i && !init_done_o};
  always_ff @(posedge clk_i) cnt_ff <= nxt_cnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_boot_quiet: assert property (!init_done_o |-> !req_ready_o && !sel)
    else $error("access before start-up wait");
  chk_boot_len: assert property ($rose(init_done_o) |-> cnt_ff >= 14'h2710)
    else $error("start-up wait too short");
  chk_wr_drive: assert property (!write_strobe_n_o |-> sel && !byte_lines_oe_n_o)
    else $error("write strobe without select or data");
  chk_rd_pins: assert property (!output_gate_n_o |-> sel && write_strobe_n_o)
    else $error("gate low outside a read");
  chk_wr_width: assert property ($fell(write_strobe_n_o) |->
    !write_strobe_n_o [*2] ##1 write_strobe_n_o)
    else $error("write strobe width wrong");
  chk_wr_addr: assert property (!write_strobe_n_o |=> $stable(location_inputs_o))
    else $error("address moved during write");
  chk_wr_data: assert property ($rose(write_strobe_n_o) |->
    $stable(byte_lines_o) && !byte_lines_oe_n_o)
    else $error("write data released early");
  chk_rd_gate: assert property ($fell(output_gate_n_o) |-> !output_gate_n_o [*3])
    else $error("read gate too short");
endmodule

// ---- verif/asr_sram_mdl.sv ----
// Behavioural model of the 8M x 8 static memory on the pin side
`timescale 1ns/10ps
module asr_sram_mdl #(
  parameter int ACC_NS = 12
) (
  input wire logic [22:0] loc_i,
  input wire logic sel_lo_i,
  input wire logic sel_hi_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o
);
  logic [7:0] mem [logic [22:0]];
  logic [7:0] last = 8'h00;
  wire sel = !sel_lo_i && sel_hi_i;
  wire act = sel && !we_n_i;
  wire drv = sel && !oe_n_i && we_n_i;
  // Unknowns at power-up must not land in the array as data
  always @(negedge act) if (^{loc_i, dq_i} !== 1'bx) mem[loc_i] = dq_i;
  always @(loc_i, drv) if (drv) last = mem.exists(loc_i) ? mem[loc_i] : 8'h00;
  // Released lines show the inverse, so a stale sample cannot pass
  assign #(ACC_NS) dq_o = drv ? last : ~last;
endmodule

// ---- verif/asr_host_tb.sv ----
// Self-checking bench for the static memory host controller
`timescale 1ns/10ps
module asr_host_tb;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, req_valid_i = 1'b0, req_write_i = 1'b0;
  logic [22:0] req_addr_i = 23'h000000, location_inputs_o;
  logic [7:0] req_wdata_i = 8'h00, rsp_rdata_o, byte_lines_o, mdl_dq;
  logic req_ready_o, rsp_valid_o, init_done_o, select_low_active_o, select_high_active_o;
  logic write_strobe_n_o, output_gate_n_o, byte_lines_oe_n_o;
  logic [8:0] e;
  logic [8:0] exp_q [$];
  logic [7:0] ref_m [logic [22:0]];
  logic [22:0] adr [16];
  int error_cnt = 0, checked = 0, seed = 32'h132feba3;
  wire [7:0] byte_lines_i = byte_lines_oe_n_o ? mdl_dq : byte_lines_o;
  wire [7:0] pins = {1'b0, select_low_active_o, select_high_active_o, write_strobe_n_o,
    output_gate_n_o, byte_lines_oe_n_o, req_ready_o, init_done_o};
  always #5 clk_i = ~clk_i;
  asr_host asr_host_i (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o),
    .req_write_i(req_write_i),
    .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i),
    .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o),
    .init_done_o(init_done_o),
    .location_inputs_o(location_inputs_o),
    .select_low_active_o(select_low_active_o),
    .select_high_active_o(select_high_active_o),
    .write_strobe_n_o(write_strobe_n_o),
    .output_gate_n_o(output_gate_n_o),
    .byte_lines_i(byte_lines_i),
    .byte_lines_o(byte_lines_o),
    .byte_lines_oe_n_o(byte_lines_oe_n_o)
  );
  asr_sram_mdl asr_sram_mdl_i (.loc_i(location_inputs_o), .sel_lo_i(select_low_active_o),
    .sel_hi_i(select_high_active_o), .we_n_i(write_strobe_n_o), .oe_n_i(output_gate_n_o),
    .dq_i(byte_lines_i), .dq_o(mdl_dq));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic boot();
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i <= 1'b0;
    exp_q.delete();
    repeat (9900) @(negedge clk_i);
    chk(pins, 8'h5c);
    repeat (300) @(negedge clk_i);
    chk(pins, 8'h5f);
  endtask
  task automatic req(input logic w, input logic [22:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk_i);
    {req_valid_i, req_write_i, req_addr_i, req_wdata_i} <= {1'b1, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 50);
    // A request that is never taken counts as a mismatch
    chk({7'h00, req_ready_o}, 8'h01);
    if (w) ref_m[a] = d;
    exp_q.push_back({!w, w ? 8'h00 : ref_m[a]});
    @(negedge clk_i);
    req_valid_i <= 1'b0;
  endtask
  // Outputs are looked at mid-cycle, where they have settled
  always @(negedge clk_i) begin
    if (rsp_valid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(8'hff, 8'h00);
      end else begin
        e = exp_q.pop_front();
        if (e[8]) chk(rsp_rdata_o, e[7:0]);
      end
    end
  end
  initial begin
    boot();
    $display("start-up test done");
    req(1'b1, 23'h000000, 8'h5a);
    req(1'b1, 23'h7fffff, 8'ha5);
    req(1'b0, 23'h000000, 8'h00);
    req(1'b0, 23'h7fffff, 8'h00);
    $display("boundary test done");
    for (int i = 0; i < 16; i++) begin
      adr[i] = 23'($random(seed));
      req(1'b1, adr[i], 8'($random(seed)));
    end
    for (int i = 15; i >= 0; i--) req(1'b0, adr[i], 8'h00);
    repeat (10) @(negedge clk_i);
    chk(8'(exp_q.size()), 8'h00);
    chk(pins, 8'h5f);
    $display("random test done");
    ce_i <= 1'b0;
    @(negedge clk_i);
    chk({7'h00, req_ready_o}, 8'h00);
    ce_i <= 1'b1;
    $display("clock enable test done");
    boot();
    req(1'b0, 23'h7fffff, 8'h00);
    repeat (10) @(negedge clk_i);
    chk(8'(exp_q.size()), 8'h00);
    $display("second reset test done");
    wrap_up();
  end
  initial begin
    #400000;
    error_cnt++;
    wrap_up();
  end
endmodule
bind asr_host asr_host_chk asr_host_chk_i (
  .clk_i(clk_i),
  .sys_rst_i(sys_rst_i),
  .ce_i(ce_i),
  .req_ready_o(req_ready_o),
  .init_done_o(init_done_o),
  .location_inputs_o(location_inputs_o),
  .select_low_active_o(select_low_active_o),
  .select_high_active_o(select_high_active_o),
  .write_strobe_n_o(write_strobe_n_o),
  .output_gate_n_o(output_gate_n_o),
  .byte_lines_o(byte_lines_o),
  .byte_lines_oe_n_o(byte_lines_oe_n_o)
);
